// ---- design/sss_map.svh ----
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
// register byte offsets
`define SSS_CTRL_OFS 8'h00
`define SSS_STOP_DLY_OFS 8'h04
`define SSS_EMRG_DLY_OFS 8'h08
`define SSS_STILL_LIM_OFS 8'h0C
`define SSS_POS_LIM_OFS 8'h10
`define SSS_STATUS_OFS 8'h14
`define SSS_IRQ_STAT_OFS 8'h18
`define SSS_IRQ_CLR_OFS 8'h1C
`define SSS_IRQ_EN_OFS 8'h20
`define SSS_SPEED_OFS 8'h24
// control field positions
`define SSS_CTRL_AUTO_BIT 0
`define SSS_CTRL_RAMPMON_BIT 1
`define SSS_CTRL_EXTRAMP_BIT 2
`define SSS_CTRL_ERR2RAMP_BIT 3
`define SSS_CTRL_TOIN_BIT 4
`define SSS_CTRL_UNSAFE_BIT 5
// reset values and delay maximum
`define SSS_CTRL_RST 32'h0000_0000
`define SSS_STOP_DLY_RST 17'h00064
`define SSS_EMRG_DLY_RST 17'h00032
`define SSS_DLY_MAX 17'h1D4C0
`define SSS_STILL_LIM_RST 24'h000154
`define SSS_POS_LIM_RST 31'h0000_0000
// timing
`define SSS_CLK_HZ 50000000
`define SSS_TICK_MS 1
`define SSS_TICK_CYC (`SSS_CLK_HZ / 1000 * `SSS_TICK_MS)
`endif

// ---- design/sss_pkg.sv ----
package sss_pkg;
   typedef enum logic [1:0] {
      SSS_IDLE = 2'b00,
      SSS_STOP = 2'b01,
      SSS_TORQUE_OFF = 2'b11
   } sss_state_t;
   // motion feedback from the drive controller
   typedef struct packed {
      logic [23:0] speed;
      logic [31:0] target_pos;
      logic [31:0] actual_pos;
      logic ctrl_enable;
      logic brake_cmd;
   } sss_drive_t;
   // commands back to the drive controller
   typedef struct packed {
      logic drive_ramp;
      logic emergency_ramp;
   } sss_ramp_t;
endpackage

// ---- design/sss_ms_tick.sv ----
`timescale 1ns/1ps
`include "sss_map.svh"
module sss_ms_tick (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick
);
   import sss_pkg::*;
   logic [15:0] cnt_q;
   // free divider; one pulse per millisecond
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_q == 16'(`SSS_TICK_CYC - 1)) begin
         cnt_q <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule // sss_ms_tick

// ---- design/sss_sync.sv ----
`timescale 1ns/1ps
module sss_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] din,
   output logic [1:0] dout
);
   import sss_pkg::*;
   logic [1:0] meta_q;
   // two stages; inactive level is high for the low-active requests
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 2'h3;
         dout <= 2'h3;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // sss_sync

// ---- design/sss_stop_seq.sv ----
`timescale 1ns/1ps
`include "sss_map.svh"
// Functional notes
// - normal stop forces torque off after normal delay, default 100 ms
// - error stop forces torque off after emergency delay, default 50 ms
// - torque off never later than expiry of the applicable delay
// - auto standstill enabled: torque off when speed below limit
// - standstill limit zero: torque off when controller enable withdrawn
// - auto standstill applies to normal and error stops alike
// - ramp monitor compares target and actual position; deviation over limit errors
// - ramp error with drive-generated ramp forces torque off at once
// - ramp error with external ramp: torque off or drive emergency ramp
// - stop request input is low-active, 0 requests, 1 releases
// - direct torque-off input low-active, 0 forces at once, bypasses delay
// - direct torque-off input evaluated only when enabled, default disabled
// - stop feedback high while stop active, low otherwise; code also holds it high in torque off, even when entered by the direct request
// - torque-off feedback high while torque off active, low otherwise
// - second brake engaged whenever torque off is active, unless the unsafe option bit is set
// - normal stop uses normal ramp, error stop uses emergency ramp
module sss_stop_seq (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // safe pins
   input wire logic stop1_request_n,
   input wire logic torque_off_request_n,
   input wire logic fault_stop,
   output logic stop1_active_fb,
   output logic torque_off_active_fb,
   // drive controller side
   input wire sss_pkg::sss_drive_t drive_in,
   output sss_pkg::sss_ramp_t ramp_out,
   output logic second_brake_out,
   output logic irq
);
   import sss_pkg::*;

   logic tick;
   logic [1:0] pins_s;
   logic stop_req;
   logic to_req;
   logic [31:0] ctrl_q;
   logic [16:0] stop_dly_q;
   logic [16:0] emrg_dly_q;
   logic [23:0] still_lim_q;
   logic [30:0] pos_lim_q;
   logic [3:0] irq_stat_q;
   logic [3:0] irq_en_q;
   logic [3:0] irq_ev;
   logic [3:0] irq_clr;
   sss_state_t state_q;
   logic emerg_q;
   logic [16:0] dly_cnt_q;
   logic ramp_err_q;
   logic to_cause;
   logic aw_hold_q;
   logic w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic [31:0] rd_mux;
   logic [31:0] pos_dev;

   // byte-lane merge used by every writable register except the interrupt clear
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // clamp a delay setting to its legal span
   function automatic logic [16:0] dly_clamp(input logic [31:0] v);
      if (v > 32'(`SSS_DLY_MAX)) begin
         return `SSS_DLY_MAX;
      end
      return v[16:0];
   endfunction

   sss_ms_tick u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   sss_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({torque_off_request_n, stop1_request_n}),
      .dout(pins_s)
   );

   assign stop_req = ~pins_s[0] | fault_stop;
   assign to_req = ctrl_q[`SSS_CTRL_TOIN_BIT] & ~pins_s[1];

   // write channel capture: address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;

   // ready flags registered; low while a word is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_hold_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready <= ~w_hold_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      end
   end

   // write response; unmapped offsets answer DECERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_q > `SSS_SPEED_OFS || awaddr_q[1:0] != 2'h0) ? 2'h3 : 2'h0;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // configuration registers; delays clamp to the legal range
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `SSS_CTRL_RST;
         stop_dly_q <= `SSS_STOP_DLY_RST;
         emrg_dly_q <= `SSS_EMRG_DLY_RST;
         still_lim_q <= `SSS_STILL_LIM_RST;
         pos_lim_q <= `SSS_POS_LIM_RST;
         irq_en_q <= 4'h0;
      end else if (wr_go) begin
         unique case (awaddr_q)
            `SSS_CTRL_OFS: ctrl_q <= lane_merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_003F;
            `SSS_STOP_DLY_OFS: stop_dly_q <= dly_clamp(lane_merge({15'h0000, stop_dly_q}, wdata_q, wstrb_q));
            `SSS_EMRG_DLY_OFS: emrg_dly_q <= dly_clamp(lane_merge({15'h0000, emrg_dly_q}, wdata_q, wstrb_q));
            `SSS_STILL_LIM_OFS: still_lim_q <= 24'(lane_merge({8'h00, still_lim_q}, wdata_q, wstrb_q));
            `SSS_POS_LIM_OFS: pos_lim_q <= 31'(lane_merge({1'b0, pos_lim_q}, wdata_q, wstrb_q));
            `SSS_IRQ_EN_OFS: irq_en_q <= 4'(lane_merge({28'h0000000, irq_en_q}, wdata_q, wstrb_q));
            default: ;
         endcase
      end
   end

   assign pos_dev = ($signed(drive_in.target_pos) >= $signed(drive_in.actual_pos)) ?
                    drive_in.target_pos - drive_in.actual_pos : drive_in.actual_pos - drive_in.target_pos;

   // latch ramp monitoring error while stopping
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ramp_err_q <= 1'b0;
      end else if (state_q == SSS_IDLE) begin
         ramp_err_q <= 1'b0;
      end else if (state_q == SSS_STOP && ctrl_q[`SSS_CTRL_RAMPMON_BIT] && pos_dev > {1'b0, pos_lim_q}) begin
         ramp_err_q <= 1'b1;
      end
   end

   // every cause, except the direct request, that ends the braking phase
   always_comb begin
      to_cause = 1'b0;
      // timer expiry always ends the stop
      if (dly_cnt_q >= (emerg_q ? emrg_dly_q : stop_dly_q)) begin
         to_cause = 1'b1;
      end
      if (ctrl_q[`SSS_CTRL_AUTO_BIT]) begin
         if (still_lim_q == 24'h000000) begin
            if (!drive_in.ctrl_enable) begin
               to_cause = 1'b1;
            end
         end else if (drive_in.speed < still_lim_q) begin
            to_cause = 1'b1;
         end
      end
      if (ramp_err_q && !(ctrl_q[`SSS_CTRL_EXTRAMP_BIT] && ctrl_q[`SSS_CTRL_ERR2RAMP_BIT])) begin
         to_cause = 1'b1;
      end
   end

   // sequencer; the direct request wins from any state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= SSS_IDLE;
      end else begin
         unique case (state_q)
            SSS_IDLE: begin
               if (to_req) begin
                  state_q <= SSS_TORQUE_OFF;
               end else if (stop_req) begin
                  state_q <= SSS_STOP;
               end
            end
            SSS_STOP: begin
               if (to_req || to_cause) begin
                  state_q <= SSS_TORQUE_OFF;
               end else if (!stop_req) begin
                  state_q <= SSS_IDLE;
               end
            end
            SSS_TORQUE_OFF: begin
               // leaving torque off needs both requests released
               if (!stop_req && !to_req) begin
                  state_q <= SSS_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dly_cnt_q <= 17'h00000;
         emerg_q <= 1'b0;
      end else if (state_q != SSS_STOP) begin
         dly_cnt_q <= 17'h00000;
         emerg_q <= fault_stop;
      end else begin
         if (tick && dly_cnt_q != `SSS_DLY_MAX) begin
            dly_cnt_q <= dly_cnt_q + 17'h00001;
         end
         // error during a stop restarts timing on the emergency delay
         if ((fault_stop || ramp_err_q) && !emerg_q) begin
            emerg_q <= 1'b1;
            dly_cnt_q <= 17'h00000;
         end
      end
   end

   // feedback, brake and ramp outputs, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop1_active_fb <= 1'b0;
         torque_off_active_fb <= 1'b0;
         second_brake_out <= 1'b1;
         ramp_out <= '0;
      end else begin
         stop1_active_fb <= (state_q != SSS_IDLE);
         torque_off_active_fb <= (state_q == SSS_TORQUE_OFF);
         // brake engaged in torque off unless unsafe option
         if (state_q == SSS_TORQUE_OFF && !ctrl_q[`SSS_CTRL_UNSAFE_BIT]) begin
            second_brake_out <= 1'b1;
         end else begin
            second_brake_out <= drive_in.brake_cmd;
         end
         // ramp selection; external error switches to drive ramp
         ramp_out.drive_ramp <= (state_q == SSS_STOP) && (!ctrl_q[`SSS_CTRL_EXTRAMP_BIT] || ramp_err_q);
         ramp_out.emergency_ramp <= (state_q == SSS_STOP) && (emerg_q || ramp_err_q);
      end
   end

   // events: stop active, torque off active, ramp error, direct request
   assign irq_ev = {to_req, ramp_err_q, state_q == SSS_TORQUE_OFF, state_q == SSS_STOP};
   assign irq_clr = (wr_go && awaddr_q == `SSS_IRQ_CLR_OFS) ? wdata_q[3:0] : 4'h0;

   // sticky status; a new event beats a simultaneous clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= 4'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
         irq <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_en_q);
      end
   end

   // read mux
   always_comb begin
      unique case (s_axi_araddr)
         `SSS_CTRL_OFS: rd_mux = ctrl_q;
         `SSS_STOP_DLY_OFS: rd_mux = {15'h0000, stop_dly_q};
         `SSS_EMRG_DLY_OFS: rd_mux = {15'h0000, emrg_dly_q};
         `SSS_STILL_LIM_OFS: rd_mux = {8'h00, still_lim_q};
         `SSS_POS_LIM_OFS: rd_mux = {1'b0, pos_lim_q};
         `SSS_STATUS_OFS: rd_mux = {26'h0000000, emerg_q, ramp_err_q, state_q, pins_s};
         `SSS_IRQ_STAT_OFS: rd_mux = {28'h0000000, irq_stat_q};
         `SSS_IRQ_EN_OFS: rd_mux = {28'h0000000, irq_en_q};
         `SSS_SPEED_OFS: rd_mux = {8'h00, drive_in.speed};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read channel: one word, answer the cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (s_axi_araddr > `SSS_SPEED_OFS || s_axi_araddr[1:0] != 2'h0) ? 2'h3 : 2'h0;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // sss_stop_seq

// ---- tb/sss_stop_seq_sva.sv ----
`timescale 1ns/1ps
module sss_stop_seq_sva
   import sss_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stop1_request_n,
   input wire logic torque_off_request_n,
   input wire logic fault_stop,
   input wire logic stop1_active_fb,
   input wire logic torque_off_active_fb,
   input wire sss_pkg::sss_drive_t drive_in,
   input wire sss_pkg::sss_ramp_t ramp_out,
   input wire logic second_brake_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // torque-off feedback implies stop feedback; feedback follows the pins within the sync and state latency
   a_off_in_stop: assert property (torque_off_active_fb |-> stop1_active_fb)
      else $error("torque off without stop feedback");
   a_stop_entry: assert property ((!stop1_request_n) [*6] |-> stop1_active_fb)
      else $error("stop request not reported");
   a_idle_release: assert property ((stop1_request_n && torque_off_request_n && !fault_stop) [*8]
      |-> !stop1_active_fb && !torque_off_active_fb) else $error("feedback stays after release");
   // drive may only release the brake when it asked for release
   a_brake_in_off: assert property (torque_off_active_fb && $past(torque_off_active_fb)
      |-> second_brake_out || !$past(drive_in.brake_cmd)) else $error("brake released in torque off");
   a_ramp_in_stop: assert property (ramp_out != 2'b00 |-> stop1_active_fb || $past(stop1_active_fb))
      else $error("ramp command outside stop");
   // read answer comes the next cycle; bus answers stand until taken
   a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // AXI
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) // AXI
      else $error("rvalid dropped");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) // AXI
      else $error("bvalid dropped");
   c_off: cover property ($rose(torque_off_active_fb));
   c_emrg: cover property (ramp_out.emergency_ramp);
   c_unsafe: cover property (torque_off_active_fb && !second_brake_out);
endmodule // sss_stop_seq_sva
bind sss_stop_seq sss_stop_seq_sva u_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .stop1_request_n, .torque_off_request_n, .fault_stop,
   .stop1_active_fb, .torque_off_active_fb, .drive_in, .ramp_out, .second_brake_out);

// ---- tb/sss_drive_model.sv ----
`timescale 1ns/1ps
module sss_drive_model
   import sss_pkg::*;
(
   input wire logic aclk,
   input wire logic [23:0] spd,
   input wire logic [31:0] perr,
   input wire logic ctl_en,
   input wire logic brk,
   output sss_pkg::sss_drive_t drive_in
);
   logic [31:0] pos_q = 32'h0;
   // target keeps moving so the monitor never sees a frozen profile
   always_ff @(posedge aclk) begin
      pos_q <= pos_q + 32'h1;
   end
   assign drive_in = '{speed: spd, target_pos: pos_q, actual_pos: pos_q - perr, ctrl_enable: ctl_en, brake_cmd: brk};
endmodule // sss_drive_model

// ---- tb/test_ss1_stop_sequencer.sv ----
`timescale 1ns/1ps
`include "sss_map.svh"
module test_ss1_stop_sequencer;
   import sss_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fault_stop = 1'b0;
   logic stop1_request_n = 1'b1, torque_off_request_n = 1'b1, ctl_en = 1'b1, brk = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, perr = 32'h0, s_axi_rdata;
   logic [23:0] spd = 24'h3E8;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic stop1_active_fb, torque_off_active_fb, second_brake_out, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   sss_drive_t drive_in;
   sss_ramp_t ramp_out;
   int err_total = 0, num_checks = 0;
   sss_stop_seq uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop1_request_n,
      .torque_off_request_n, .fault_stop, .stop1_active_fb, .torque_off_active_fb, .drive_in, .ramp_out,
      .second_brake_out, .irq);
   sss_drive_model drv (.aclk, .spd, .perr, .ctl_en, .brk, .drive_in);
   // 50 MHz
   always #10 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // address and data offered together, each dropped once taken
   // only the watchdog ends a wait for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk(32'(s_axi_rresp), 32'(er));
   endtask
   // bounded wait; a short limit with exp low proves no early torque off
   task automatic wait_off(input int lim, input logic exp);
      int n = 0;
      while (torque_off_active_fb !== 1'b1 && n < lim) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(torque_off_active_fb), 32'(exp));
   endtask
   task automatic idle;
      @(posedge aclk);
      stop1_request_n <= 1'b1;
      torque_off_request_n <= 1'b1;
      fault_stop <= 1'b0;
      perr <= 32'h0;
      spd <= 24'h3E8;
      ctl_en <= 1'b1;
      brk <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(32'({stop1_active_fb, torque_off_active_fb}), 32'h0);
      wr(`SSS_CTRL_OFS, 32'h0);
      wr(`SSS_IRQ_CLR_OFS, 32'hF);
   endtask
   task automatic t_regs;
      chk(32'(second_brake_out), 32'h1);
      rd_chk(`SSS_CTRL_OFS, 32'h0);
      rd_chk(`SSS_STOP_DLY_OFS, 32'h64);
      rd_chk(`SSS_EMRG_DLY_OFS, 32'h32);
      rd_chk(`SSS_STILL_LIM_OFS, 32'h154);
      rd_chk(`SSS_POS_LIM_OFS, 32'h0);
      rd_chk(`SSS_STATUS_OFS, 32'h3);
      rd_chk(`SSS_SPEED_OFS, 32'h3E8);
      rd_chk(8'h40, 32'h0, 2'b11);
      wr(8'h40, 32'h1, 2'b11);
      wr(`SSS_STOP_DLY_OFS, 32'h30D40);
      rd_chk(`SSS_STOP_DLY_OFS, 32'h1D4C0);
      $display("done: register defaults");
   endtask
   task automatic t_delay;
      wr(`SSS_STOP_DLY_OFS, 32'h0);
      wr(`SSS_IRQ_EN_OFS, 32'h2);
      @(posedge aclk);
      stop1_request_n <= 1'b0;
      wait_off(8, 1'b1);
      repeat (2) @(posedge aclk);
      chk(32'({stop1_active_fb, second_brake_out, irq}), 32'h7);
      wr(`SSS_IRQ_EN_OFS, 32'h0);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0);
      idle;
      rd_chk(`SSS_IRQ_STAT_OFS, 32'h0);
      wr(`SSS_STOP_DLY_OFS, 32'h1);
      @(posedge aclk);
      stop1_request_n <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(32'(ramp_out), 32'h2);
      wait_off(50020, 1'b1);
      idle;
      $display("done: stop delay");
   endtask
   task automatic t_direct;
      @(posedge aclk);
      torque_off_request_n <= 1'b0;
      wait_off(20, 1'b0);
      wr(`SSS_CTRL_OFS, 32'h10);
      wait_off(8, 1'b1);
      wr(`SSS_CTRL_OFS, 32'h30);
      brk <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(32'(second_brake_out), 32'h0);
      wr(`SSS_CTRL_OFS, 32'h10);
      repeat (3) @(posedge aclk);
      chk(32'(second_brake_out), 32'h1);
      idle;
      $display("done: direct torque off");
   endtask
   task automatic t_auto;
      wr(`SSS_CTRL_OFS, 32'h1);
      @(posedge aclk);
      stop1_request_n <= 1'b0;
      wait_off(20, 1'b0);
      spd <= 24'h64;
      wait_off(8, 1'b1);
      idle;
      wr(`SSS_CTRL_OFS, 32'h1);
      wr(`SSS_EMRG_DLY_OFS, 32'h1);
      fault_stop <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(32'(ramp_out), 32'h3);
      spd <= 24'h64;
      wait_off(8, 1'b1);
      idle;
      wr(`SSS_STILL_LIM_OFS, 32'h0);
      wr(`SSS_CTRL_OFS, 32'h1);
      stop1_request_n <= 1'b0;
      wait_off(20, 1'b0);
      ctl_en <= 1'b0;
      wait_off(8, 1'b1);
      idle;
      wr(`SSS_EMRG_DLY_OFS, 32'h0);
      fault_stop <= 1'b1;
      wait_off(8, 1'b1);
      idle;
      $display("done: standstill and error stop");
   endtask
   task automatic t_ramp;
      // a zero emergency delay left over would end the external-ramp stop at once
      wr(`SSS_EMRG_DLY_OFS, 32'h1);
      wr(`SSS_POS_LIM_OFS, 32'hA);
      wr(`SSS_CTRL_OFS, 32'h2);
      perr <= 32'hA;
      stop1_request_n <= 1'b0;
      wait_off(20, 1'b0);
      perr <= 32'hB;
      wait_off(8, 1'b1);
      idle;
      wr(`SSS_CTRL_OFS, 32'hE);
      perr <= 32'hB;
      stop1_request_n <= 1'b0;
      wait_off(20, 1'b0);
      chk(32'(ramp_out), 32'h3);
      idle;
      wr(`SSS_CTRL_OFS, 32'h6);
      perr <= 32'hB;
      stop1_request_n <= 1'b0;
      wait_off(8, 1'b1);
      idle;
      $display("done: ramp monitor");
   endtask
   // whole run is about 50k cycles
   initial begin
      repeat (90000) @(posedge aclk);
      err_total++;
      $display("wrong value at %0t: watchdog expired", $time);
      finish_test;
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs;
      t_delay;
      t_direct;
      t_auto;
      t_ramp;
      finish_test;
   end
endmodule // test_ss1_stop_sequencer
